// [logic/exec_core.v]
// two-cycle execution core: alu group, flags and interrupt group
`timescale 1ns/1ps
`default_nettype none
`include "exec_defines.vh"

// Behaviour
// - interrupt return reloads popped address unincremented
// - interrupt return restores saved zero, carry
// - interrupt return operand sets or clears enable
// - enable/disable instructions only write enable flag
// - accepted interrupt jumps to address FF
// - load writes register, flags unchanged
// - every instruction takes exactly two cycles
// - and with register or constant, flags updated
// - or with register or constant, flags updated
// - xor with register or constant, flags updated
// - add ignores incoming carry, flags updated
// - add with carry includes carry flag
// - subtract ignores incoming carry, flags updated
// - carry set on subtraction underflow
// - subtract with borrow includes carry flag
// - four-bit register fields, eight-bit constants
// - fifteen-entry cyclic stack, interrupt pushes pc
module exec_core #(
    parameter DATA_W = 8,
    parameter ADDR_W = 8,
    parameter REG_SEL_W = 4,
    parameter STACK_DEPTH = `STACK_DEPTH
) (
    input wire clk,
    input wire rst,
    input wire [`INSTR_W-1:0] instruction,
    input wire interrupt,
    input wire [REG_SEL_W-1:0] reg_peek_sel,
    output wire [ADDR_W-1:0] address,
    output wire zero_flag,
    output wire carry_flag,
    output wire int_enable,
    output wire int_ack,
    output reg [DATA_W-1:0] reg_peek_data
);

    localparam NUM_REGS = 1 << REG_SEL_W;
    localparam [ADDR_W-1:0] VECTOR = `INT_VECTOR;
    localparam [ADDR_W-1:0] START = `RESET_PC;
    localparam [ADDR_W-1:0] STEP = `PC_STEP;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function is_alu_class;
        input [3:0] cls;
        begin
            is_alu_class = (cls[3] == 1'b0) || (cls == `CLASS_REG_FORM);
        end
    endfunction

    function flag_writer;
        input [2:0] op;
        begin
            flag_writer = (op != `ALU_LOAD);
        end
    endfunction

    function sel_hits;
        input [REG_SEL_W-1:0] sel;
        input integer idx;
        begin
            sel_hits = (sel == idx[REG_SEL_W-1:0]);
        end
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    reg phase_q;
    reg [ADDR_W-1:0] pc_q;
    reg [ADDR_W-1:0] pc_d;
    reg zero_q;
    reg carry_q;
    reg ie_q;
    reg zero_d;
    reg carry_d;
    reg ie_d;
    reg saved_zero_q;
    reg saved_carry_q;
    reg int_ack_q;
    wire [DATA_W-1:0] regs [0:NUM_REGS-1];

    wire [3:0] cls;
    wire [REG_SEL_W-1:0] sx_sel;
    wire [REG_SEL_W-1:0] sy_sel;
    wire [DATA_W-1:0] immediate_constant;
    wire [DATA_W-1:0] first_operand_register;
    wire [DATA_W-1:0] second_operand_register;
    wire reg_form;
    wire alu_instr;
    wire int_instr;
    wire return_from_interrupt;
    wire [1:0] int_sel;
    wire [2:0] alu_op;
    wire [DATA_W-1:0] operand_b;
    wire [DATA_W-1:0] alu_result;
    wire alu_carry;
    wire alu_zero;
    wire exec;
    wire take_int;
    wire rf_we;
    wire push;
    wire pop;
    wire [ADDR_W-1:0] stack_top;

    // ------------------------------------------------------------
    // field extraction and operand selection
    // ------------------------------------------------------------
    assign cls = instruction[`F_CLASS];
    assign sx_sel = instruction[`F_SX];
    assign sy_sel = instruction[`F_SY];
    assign immediate_constant = instruction[`F_KK];
    assign reg_form = (cls == `CLASS_REG_FORM);
    assign alu_instr = is_alu_class(cls);
    assign int_instr = (cls == `CLASS_INT_GROUP);
    assign int_sel = instruction[`F_INT_SEL];
    assign return_from_interrupt = int_instr && instruction[`F_INT_RET];
    assign alu_op = reg_form ? instruction[`F_REG_OP] : cls[2:0];
    assign first_operand_register = regs[sx_sel];
    assign second_operand_register = regs[sy_sel];
    assign operand_b = reg_form ? second_operand_register
                                : immediate_constant;

    // execute half of every two-cycle instruction
    assign exec = (phase_q == `PHASE_EXEC);
    // interrupt replaces the instruction fetched in this slot
    assign take_int = exec && ie_q && interrupt;
    assign rf_we = exec && !take_int && alu_instr;
    assign push = take_int;
    assign pop = exec && !take_int && return_from_interrupt;

    alu_unit #(
        .WIDTH(DATA_W)
    ) u_alu (
        .op(alu_op),
        .a(first_operand_register),
        .b(operand_b),
        .carry_in(carry_q),
        .result(alu_result),
        .carry_out(alu_carry),
        .zero_out(alu_zero)
    );

    pc_stack #(
        .DEPTH(STACK_DEPTH),
        .PTR_W(`STACK_PTR_W),
        .ADDR_W(ADDR_W)
    ) u_stack (
        .clk(clk),
        .rst(rst),
        .push(push),
        .pop(pop),
        .push_addr(pc_q),
        .top_addr(stack_top)
    );

    // ------------------------------------------------------------
    // program counter sequencing
    // ------------------------------------------------------------
    always @*
    begin
        pc_d = pc_q;
        if (exec)
        begin
            if (take_int)
            begin
                pc_d = VECTOR;
            end
            else if (pop)
            begin
                pc_d = stack_top;
            end
            else
            begin
                pc_d = pc_q + STEP;
            end
        end
    end

    // ------------------------------------------------------------
    // next flag and interrupt enable values
    // ------------------------------------------------------------
    always @*
    begin
        zero_d = zero_q;
        carry_d = carry_q;
        ie_d = ie_q;
        if (take_int)
        begin
            ie_d = 1'b0;
        end
        else if (exec && alu_instr && flag_writer(alu_op))
        begin
            zero_d = alu_zero;
            carry_d = alu_carry;
        end
        else if (exec && int_instr)
        begin
            case (int_sel)
                `INT_DISABLE:
                begin
                    ie_d = 1'b0;
                end
                `INT_ENABLE:
                begin
                    ie_d = 1'b1;
                end
                `INT_RET_DISABLE:
                begin
                    ie_d = 1'b0;
                    zero_d = saved_zero_q;
                    carry_d = saved_carry_q;
                end
                `INT_RET_ENABLE:
                begin
                    ie_d = 1'b1;
                    zero_d = saved_zero_q;
                    carry_d = saved_carry_q;
                end
                default:
                begin
                    ie_d = ie_q;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // sequencer, flags and interrupt enable
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (rst)
        begin
            phase_q <= `PHASE_FETCH;
            pc_q <= START;
            zero_q <= `RESET_FLAG;
            carry_q <= `RESET_FLAG;
            ie_q <= `RESET_FLAG;
            saved_zero_q <= `RESET_FLAG;
            saved_carry_q <= `RESET_FLAG;
            int_ack_q <= 1'b0;
        end
        else
        begin
            phase_q <= ~phase_q;
            pc_q <= pc_d;
            int_ack_q <= take_int;
            zero_q <= zero_d;
            carry_q <= carry_d;
            ie_q <= ie_d;
            // single saved copy: nested entry overwrites it
            if (take_int)
            begin
                saved_zero_q <= zero_q;
                saved_carry_q <= carry_q;
            end
        end
    end

    // ------------------------------------------------------------
    // register file and observation port
    // ------------------------------------------------------------
    // one word per register, each with its own write strobe
    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g = g + 1)
        begin : gen_reg
            reg [DATA_W-1:0] word_q;
            always @(posedge clk)
            begin
                if (rf_we && sel_hits(sx_sel, g))
                begin
                    word_q <= alu_result;
                end
            end
            assign regs[g] = word_q;
        end
    endgenerate

    always @(posedge clk)
    begin
        if (rst)
        begin
            reg_peek_data <= {DATA_W{1'b0}};
        end
        else
        begin
            reg_peek_data <= regs[reg_peek_sel];
        end
    end

    assign address = pc_q;
    assign zero_flag = zero_q;
    assign carry_flag = carry_q;
    assign int_enable = ie_q;
    assign int_ack = int_ack_q;

endmodule
`default_nettype wire

// [logic/exec_defines.vh]
// constants for the execution core: encodings, field positions, reset values
`ifndef EXEC_DEFINES_VH
`define EXEC_DEFINES_VH

// instruction word fields
`define INSTR_W 16
`define F_CLASS 15:12
`define F_SX 11:8
`define F_SY 7:4
`define F_KK 7:0
`define F_REG_OP 2:0
`define F_INT_SEL 1:0
`define F_INT_RET 1
`define F_INT_EN 0

// instruction classes; 0..7 are constant forms carrying the alu op itself
`define CLASS_REG_FORM 4'h8
`define CLASS_INT_GROUP 4'h9

// alu operations
`define ALU_LOAD 3'h0
`define ALU_AND 3'h1
`define ALU_OR 3'h2
`define ALU_XOR 3'h3
`define ALU_ADD 3'h4
`define ALU_ADD_WITH_CARRY 3'h5
`define ALU_SUB 3'h6
`define ALU_SUBTRACT_WITH_BORROW 3'h7

// interrupt group selector
`define INT_DISABLE 2'h0
`define INT_ENABLE 2'h1
`define INT_RET_DISABLE 2'h2
`define INT_RET_ENABLE 2'h3

// addresses and reset values
`define INT_VECTOR 8'hFF
`define RESET_PC 8'h00
`define PC_STEP 8'h01
`define PHASE_FETCH 1'b0
`define PHASE_EXEC 1'b1
`define RESET_FLAG 1'b0
`define STACK_DEPTH 15
`define STACK_PTR_W 4

`endif

// [logic/alu_unit.v]
// logic and arithmetic unit with zero and carry generation
`timescale 1ns/1ps
`default_nettype none
`include "exec_defines.vh"

module alu_unit #(
    parameter WIDTH = 8
) (
    input wire [2:0] op,
    input wire [WIDTH-1:0] a,
    input wire [WIDTH-1:0] b,
    input wire carry_in,
    output reg [WIDTH-1:0] result,
    output reg carry_out,
    output wire zero_out
);

    reg [WIDTH:0] wide;

    always @*
    begin
        wide = {(WIDTH+1){1'b0}};
        result = b;
        carry_out = 1'b0;
        case (op)
            `ALU_LOAD:
            begin
                result = b;
            end
            `ALU_AND:
            begin
                result = a & b;
            end
            `ALU_OR:
            begin
                result = a | b;
            end
            `ALU_XOR:
            begin
                result = a ^ b;
            end
            `ALU_ADD:
            begin
                wide = {1'b0, a} + {1'b0, b};
                result = wide[WIDTH-1:0];
                carry_out = wide[WIDTH];
            end
            `ALU_ADD_WITH_CARRY:
            begin
                wide = {1'b0, a} + {1'b0, b} + {{WIDTH{1'b0}}, carry_in};
                result = wide[WIDTH-1:0];
                carry_out = wide[WIDTH];
            end
            `ALU_SUB:
            begin
                wide = {1'b0, a} - {1'b0, b};
                result = wide[WIDTH-1:0];
                carry_out = wide[WIDTH];
            end
            `ALU_SUBTRACT_WITH_BORROW:
            begin
                wide = {1'b0, a} - {1'b0, b} - {{WIDTH{1'b0}}, carry_in};
                result = wide[WIDTH-1:0];
                carry_out = wide[WIDTH];
            end
            default:
            begin
                result = b;
            end
        endcase
    end

    // logic ops leave carry_out at zero
    assign zero_out = (result == {WIDTH{1'b0}});

endmodule
`default_nettype wire

// [logic/pc_stack.v]
// cyclic program counter stack, oldest entry overwritten when full
`timescale 1ns/1ps
`default_nettype none
`include "exec_defines.vh"

module pc_stack #(
    parameter DEPTH = `STACK_DEPTH,
    parameter PTR_W = `STACK_PTR_W,
    parameter ADDR_W = 8
) (
    input wire clk,
    input wire rst,
    input wire push,
    input wire pop,
    input wire [ADDR_W-1:0] push_addr,
    output wire [ADDR_W-1:0] top_addr
);

    localparam [PTR_W-1:0] LAST = DEPTH - 1;
    localparam [PTR_W-1:0] ONE = 1;

    reg [ADDR_W-1:0] mem [0:DEPTH-1];
    reg [PTR_W-1:0] ptr_q;
    wire [PTR_W-1:0] ptr_up;
    wire [PTR_W-1:0] ptr_down;

    // wrap both ways so the buffer never needs a software reset
    assign ptr_up = (ptr_q == LAST) ? {PTR_W{1'b0}} : ptr_q + ONE;
    assign ptr_down = (ptr_q == {PTR_W{1'b0}}) ? LAST : ptr_q - ONE;
    assign top_addr = mem[ptr_q];

    always @(posedge clk)
    begin
        if (rst)
        begin
            ptr_q <= {PTR_W{1'b0}};
        end
        else if (push)
        begin
            ptr_q <= ptr_up;
        end
        else if (pop)
        begin
            ptr_q <= ptr_down;
        end
    end

    always @(posedge clk)
    begin
        if (push)
        begin
            mem[ptr_up] <= push_addr;
        end
    end

endmodule
`default_nettype wire

// [tb/exec_core_asserts.sv]
// port-level checks for the two-cycle execution core
`timescale 1ns/1ps
`default_nettype none
`include "exec_defines.vh"

module exec_core_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] instruction,
    input wire logic interrupt,
    input wire logic [7:0] address,
    input wire logic zero_flag,
    input wire logic carry_flag,
    input wire logic int_enable,
    input wire logic int_ack
);
// ----------------------------------------
// history of the previous edge
// ----------------------------------------
logic [7:0] last_pc_q;
logic [15:0] instr_q;
logic [7:0] ret_pc_q;
logic zs_q;
logic cs_q;
wire moved = address != last_pc_q;
wire ret_op = moved && !int_ack && instr_q[15:12] == 4'h9 && instr_q[1];

always @(posedge clk)
begin
    last_pc_q <= address;
    instr_q <= instruction;
    if (int_ack)
    begin
        ret_pc_q <= last_pc_q;
        zs_q <= zero_flag;
        cs_q <= carry_flag;
    end
end

default clocking @(posedge clk); endclocking
default disable iff (rst);

a_pc_holds: assert property ($changed(address) |=> $stable(address))
    else $error("address moved on back-to-back edges");
a_irq_vector: assert property ($rose(int_ack) |->
    address == `INT_VECTOR && !int_enable) else $error("bad vector entry");
a_ack_pulse: assert property (int_ack |=> !int_ack)
    else $error("ack longer than one cycle");
a_ack_cause: assert property ($rose(int_ack) |->
    $past(int_enable) && $past(interrupt)) else $error("ack without cause");
a_irq_flags: assert property ($rose(int_ack) |->
    $stable(zero_flag) && $stable(carry_flag)) else $error("flags hit");
a_ie_rise: assert property ($rose(int_enable) |->
    instr_q[15:12] == 4'h9 && instr_q[0]) else $error("enable rose");
a_ie_fall: assert property ($fell(int_enable) |-> int_ack ||
    (instr_q[15:12] == 4'h9 && !instr_q[0])) else $error("enable fell");
a_return_pc: assert property (ret_op |-> address == ret_pc_q)
    else $error("return address wrong");
a_return_flags: assert property (ret_op |->
    zero_flag == zs_q && carry_flag == cs_q) else $error("flags lost");
a_return_ie: assert property (ret_op |-> int_enable == instr_q[0])
    else $error("return enable wrong");
a_load_flags: assert property (moved && !int_ack &&
    instr_q[15:12] == 4'h0 |-> $stable(zero_flag) && $stable(carry_flag))
    else $error("load touched flags");
a_logic_carry: assert property (moved && !int_ack &&
    instr_q[15:12] inside {4'h1, 4'h2, 4'h3} |-> !carry_flag)
    else $error("logic op left carry");
endmodule

bind exec_core exec_core_asserts u_chk (.clk(clk), .rst(rst),
    .instruction(instruction), .interrupt(interrupt), .address(address),
    .zero_flag(zero_flag), .carry_flag(carry_flag),
    .int_enable(int_enable), .int_ack(int_ack));
`default_nettype wire

// [tb/test_alu_and_interrupt_return.sv]
// self-checking bench for the two-cycle execution core
`timescale 1ns/1ps
`default_nettype none
`include "exec_defines.vh"

module test_alu_and_interrupt_return;
logic clk = 1'b0;
logic rst = 1'b1;
logic [15:0] instruction = 16'hA000;
logic interrupt = 1'b0;
logic [3:0] reg_peek_sel = 4'h0;
wire [7:0] address;
wire zero_flag, carry_flag, int_enable, int_ack;
wire [7:0] reg_peek_data;
int fail_count = 0;
int n_checks = 0;
logic [7:0] r_e [16];
logic [7:0] pc_e = 8'h00;
logic z_e = 1'b0;
logic c_e = 1'b0;
localparam logic [15:0] prog [20] = '{16'h0127, 16'h0235, 16'h6135,
    16'h0300, 16'h7300, 16'h5301, 16'h4301, 16'h8126, 16'h8327, 16'h8325,
    16'h1100, 16'h2155, 16'h3155, 16'h8121, 16'h8122, 16'h8123, 16'h8110,
    16'h04FF, 16'h4401, 16'h8410};

exec_core dut (.clk(clk), .rst(rst), .instruction(instruction),
    .interrupt(interrupt), .reg_peek_sel(reg_peek_sel), .address(address),
    .zero_flag(zero_flag), .carry_flag(carry_flag), .int_enable(int_enable),
    .int_ack(int_ack), .reg_peek_data(reg_peek_data));

always #12.5 clk = ~clk;

task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
        fail_count++;
        $display("mismatch at %0t ns: got %h exp %h", $time, got, exp);
    end
endtask

// one fetch and exec pair, then the new address
task step(input logic [15:0] i, input logic [3:0] s, input logic [7:0] p);
    @(posedge clk);
    instruction <= i;
    reg_peek_sel <= s;
    @(posedge clk);
    #1;
    pc_e = p;
    chk(address, p);
endtask

task op(input logic [15:0] i);
    logic [7:0] a;
    logic [7:0] b;
    logic [8:0] w;
    logic [2:0] o;
    a = r_e[i[11:8]];
    o = i[15] ? i[2:0] : i[14:12];
    b = i[15] ? r_e[i[7:4]] : i[7:0];
    case (o)
        3'h0: w = {c_e, b};
        3'h1: w = {1'b0, a & b};
        3'h2: w = {1'b0, a | b};
        3'h3: w = {1'b0, a ^ b};
        3'h4: w = a + b;
        3'h5: w = a + b + c_e;
        3'h6: w = a - b;
        default: w = a - b - c_e;
    endcase
    r_e[i[11:8]] = w[7:0];
    if (o != 3'h0)
    begin
        c_e = w[8];
        z_e = w[7:0] == 8'h00;
    end
    step(i, i[11:8], pc_e + 8'h01);
    chk({6'h0, zero_flag, carry_flag}, {6'h0, z_e, c_e});
    step(16'hA000, i[11:8], pc_e + 8'h01);
    chk(reg_peek_data, r_e[i[11:8]]);
endtask

task t_reset;
    chk(address, 8'h00);
    chk({5'h0, zero_flag, carry_flag, int_enable}, 8'h00);
    chk({7'h0, int_ack}, 8'h00);
    chk(reg_peek_data, 8'h00);
endtask

task t_alu;
    foreach (prog[k]) op(prog[k]);
endtask

task t_irq;
    logic [7:0] ret;
    step(16'h9001, 4'h0, pc_e + 8'h01);
    chk({6'h0, zero_flag, carry_flag}, {6'h0, z_e, c_e});
    chk({7'h0, int_enable}, 8'h01);
    ret = pc_e;
    interrupt <= 1'b1;
    step(16'h41FF, 4'h1, `INT_VECTOR);
    chk({6'h0, int_ack, int_enable}, 8'h02);
    interrupt <= 1'b0;
    op(16'h2101);
    step(16'h9003, 4'h0, ret);
    z_e = 1'b1;
    c_e = 1'b1;
    chk({5'h0, zero_flag, carry_flag, int_enable}, 8'h07);
    op(16'h41FF);
    ret = pc_e;
    interrupt <= 1'b1;
    step(16'hA000, 4'h0, `INT_VECTOR);
    interrupt <= 1'b0;
    step(16'h9002, 4'h0, ret);
    chk({7'h0, int_enable}, 8'h00);
    interrupt <= 1'b1;
    step(16'h9000, 4'h0, pc_e + 8'h01);
    chk({6'h0, int_ack, int_enable}, 8'h00);
    interrupt <= 1'b0;
endtask

task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
        $display("ALL TESTS PASSED");
    else
        $display("TESTS FAILED");
    $finish;
endtask

initial
begin
    #100000;
    fail_count++;
    report_and_stop();
end

initial
begin
    repeat (8) @(posedge clk);
    #1;
    t_reset();
    @(posedge clk);
    rst <= 1'b0;
    t_alu();
    t_irq();
    report_and_stop();
end
endmodule
`default_nettype wire
